// ==== fio_regs.svh ====
// Register offsets, field positions, reset values and data values
// -------------------------------------------------------------
// Functional notes
// - Read target and write target of each fixed address are chosen separately.
// - Reserved fixed addresses complete internally: writes dropped, reads give all ones.
// - Unlisted, unclaimed addresses are not decoded and terminate internally.
// - Internal-unit cycles are claimed and passed over the sideband bridge.
// - 20h-21h, A0h-A1h and their 2xh-3xh, Axh-Bxh aliases always reach interrupt unit.
// - 4D0h-4D1h always reach the interrupt unit, no enable bit.
// - Super-I/O, micro, keyboard, gameport ranges go out only when enabled.
// - 61h always reaches NMI; 63h, 65h, 67h alias it only when enabled.
// - 70h-7Fh reach RTC; 70h writes also NMI; upper-bank off aliases 72-73, 76-77, 7A-7B, 7E-7F.
// - POST-code ports go to PCIe when route bit set, else LPC/eSPI.
// - POST-code writes always go out; reads may be answered internally.
// - With alias disabled, 63h, 65h, 67h cycles terminate internally.
// - Forwarded legacy cycles go to eSPI when strap is 1, LPC when 0.
// -------------------------------------------------------------
`ifndef FIO_REGS_SVH
`define FIO_REGS_SVH

// -------------------------------------------------------------
// Register map, byte addresses
// -------------------------------------------------------------
`define FIO_OFS_CTRL 4'h0
`define FIO_OFS_STATUS 4'h4
`define FIO_OFS_POST 4'h8
`define FIO_AW 4

// -------------------------------------------------------------
// Control fields
// -------------------------------------------------------------
`define FIO_B_SUPERIO 0
`define FIO_B_MICRO_ALT 1
`define FIO_B_MICRO 2
`define FIO_B_KBD 3
`define FIO_B_GAME_LOW 4
`define FIO_B_GAME_HIGH 5
`define FIO_B_NMI_ALIAS 6
`define FIO_B_RTC_UPPER 7
`define FIO_B_POST_ROUTE 8
`define FIO_B_POST_RD_LOCAL 9
`define FIO_CTRL_W 10
`define FIO_CTRL_RST 10'h000

// -------------------------------------------------------------
// Status fields
// -------------------------------------------------------------
`define FIO_S_STRAP 0
`define FIO_S_TGT_LSB 4
`define FIO_S_ADDR_LSB 16

// -------------------------------------------------------------
// Data values
// -------------------------------------------------------------
`define FIO_ALL_ONES 8'hff
`define FIO_POST_RST 8'h00

`endif

// ==== fio_pkg.sv ====
// Types shared by the fixed I/O decoder files
package fio_pkg;

  typedef enum logic [3:0] {
    TGT_NONE, TGT_RSVD, TGT_LOCAL, TGT_PIC, TGT_PIT, TGT_NMI, TGT_RTC,
    TGT_PM, TGT_RSTGEN, TGT_LPC, TGT_ESPI, TGT_PCIE
  } fio_tgt_type;

  typedef enum logic [1:0] {ST_IDLE, ST_DEC, ST_WAIT} fio_state_type;

endpackage

// ==== fio_decode.sv ====
// Combinational fixed I/O address lookup
`timescale 1ns/1ps
`include "fio_regs.svh"
module fio_decode
  import fio_pkg::*;
(
  // Cycle
  input wire logic [15:0] addr,
  input wire logic write,
  // Live control bits and strap
  input wire logic [`FIO_CTRL_W-1:0] ctrl,
  input wire logic espi_sel,
  // Result
  output fio_tgt_type tgt,
  output logic [15:0] tgt_addr,
  output logic nmi_copy
);
  fio_tgt_type rd_tgt;
  fio_tgt_type wr_tgt;
  fio_tgt_type leg;
  logic [7:0] lo;
  logic page0;

  always_comb begin
    lo = addr[7:0];
    page0 = (addr[15:8] == 8'h00);
    leg = espi_sel ? TGT_ESPI : TGT_LPC;
    rd_tgt = TGT_NONE;
    tgt_addr = addr;
    if (page0 && (lo[7:5] == 3'h1 || lo[7:5] == 3'h5) && !lo[1]) begin
      rd_tgt = TGT_PIC;
    end else if (addr == 16'h04d0 || addr == 16'h04d1) begin
      rd_tgt = TGT_PIC;
    end else if (addr[15:4] == 12'h020) begin
      if (addr[3] ? ctrl[`FIO_B_GAME_HIGH] : ctrl[`FIO_B_GAME_LOW]) rd_tgt = leg;
    end else if (addr == 16'h0cf9) begin
      rd_tgt = TGT_RSTGEN;
    end else if (page0 && lo[7:4] == 4'h7) begin
      rd_tgt = TGT_RTC;
      if (!ctrl[`FIO_B_RTC_UPPER] && lo[1]) tgt_addr = {addr[15:3], 2'h0, addr[0]};
    end else if (page0 && (lo[7:4] == 4'h8 || lo[7:4] == 4'h9)) begin
      case (lo[3:0])
        4'h0, 4'h4, 4'h5, 4'h6, 4'h8, 4'hc, 4'hd, 4'he: begin
          if (lo[4]) rd_tgt = leg;
          else rd_tgt = ctrl[`FIO_B_POST_ROUTE] ? TGT_PCIE : leg;
        end
        4'h2: rd_tgt = lo[4] ? TGT_RSTGEN : TGT_NONE;
        default: rd_tgt = TGT_NONE;
      endcase
    end else if (page0) begin
      case (lo)
        8'h2e, 8'h2f: if (ctrl[`FIO_B_SUPERIO]) rd_tgt = leg;
        8'h4e, 8'h4f: if (ctrl[`FIO_B_MICRO_ALT]) rd_tgt = leg;
        8'h60, 8'h64: if (ctrl[`FIO_B_KBD]) rd_tgt = leg;
        8'h62, 8'h66: if (ctrl[`FIO_B_MICRO]) rd_tgt = leg;
        8'h40, 8'h42, 8'h43, 8'h50, 8'h52, 8'h53: rd_tgt = TGT_PIT;
        8'h41, 8'h51: rd_tgt = TGT_RSVD;
        8'h61: rd_tgt = TGT_NMI;
        8'h63, 8'h65, 8'h67: begin
          if (ctrl[`FIO_B_NMI_ALIAS]) begin
            rd_tgt = TGT_NMI;
            tgt_addr = 16'h0061;
          end else begin
            rd_tgt = TGT_NONE;
          end
        end
        8'hb2, 8'hb3: rd_tgt = TGT_PM;
        default: rd_tgt = TGT_NONE;
      endcase
    end
    wr_tgt = rd_tgt;
    // POST-code reads may be served here; writes always leave
    if (rd_tgt inside {TGT_LPC, TGT_ESPI, TGT_PCIE} && page0 && lo[7:4] == 4'h8
        && ctrl[`FIO_B_POST_RD_LOCAL]) begin
      rd_tgt = TGT_LOCAL;
    end
    tgt = write ? wr_tgt : rd_tgt;
    nmi_copy = write && tgt == TGT_RTC && tgt_addr == 16'h0070;
  end
endmodule

// ==== fio_top.sv ====
// Fixed I/O address decoder with Avalon-MM control registers
`timescale 1ns/1ps
`include "fio_regs.svh"
module fio_top
  import fio_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [`FIO_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Legacy bus select strap
  input wire logic espi_strap,
  // Host I/O cycles
  input wire logic io_req,
  input wire logic io_write,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic io_busy,
  output logic io_done,
  output logic [7:0] io_rdata,
  // Target side
  output logic tgt_req,
  output fio_tgt_type tgt_sel,
  output logic tgt_sideband,
  output logic tgt_write,
  output logic [15:0] tgt_addr,
  output logic [7:0] tgt_wdata,
  output logic tgt_nmi_copy,
  input wire logic tgt_ack,
  input wire logic [7:0] tgt_rdata
);
  fio_state_type state_q;
  logic [`FIO_CTRL_W-1:0] ctrl_q;
  logic strap_q;
  logic strap_done_q;
  logic [7:0] post_q;
  logic [15:0] cur_addr_q;
  logic cur_wr_q;
  logic [7:0] cur_wdata_q;
  fio_tgt_type last_tgt_q;
  fio_tgt_type dec_tgt;
  logic [15:0] dec_addr;
  logic dec_nmi;
  logic dec_local;
  logic dec_internal;
  logic dec_post;
  logic bus_hit;

  // -------------------------------------------------------------
  // Address lookup
  // -------------------------------------------------------------
  fio_decode u_decode (
    .addr(cur_addr_q),
    .write(cur_wr_q),
    .ctrl(ctrl_q),
    .espi_sel(strap_q),
    .tgt(dec_tgt),
    .tgt_addr(dec_addr),
    .nmi_copy(dec_nmi)
  );

  assign dec_local = dec_tgt inside {TGT_NONE, TGT_RSVD, TGT_LOCAL};
  assign dec_internal = dec_tgt inside {TGT_PIC, TGT_PIT, TGT_NMI, TGT_RTC,
                                        TGT_PM, TGT_RSTGEN};
  assign dec_post = cur_addr_q[15:8] == 8'h00 && cur_addr_q[7:4] == 4'h8;

  // -------------------------------------------------------------
  // Strap capture after reset release
  // -------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      strap_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_q <= espi_strap;
      strap_done_q <= 1'b1;
    end
  end

  // -------------------------------------------------------------
  // Avalon-MM slave, one wait cycle per access
  // -------------------------------------------------------------
  assign bus_hit = (avs_read || avs_write) && avs_waitrequest;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !bus_hit;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      case (avs_address)
        `FIO_OFS_CTRL: avs_readdata <= {22'h0, ctrl_q};
        `FIO_OFS_STATUS: begin
          avs_readdata <= 32'h0000_0000;
          avs_readdata[`FIO_S_STRAP] <= strap_q;
          avs_readdata[`FIO_S_TGT_LSB +: 4] <= last_tgt_q;
          avs_readdata[`FIO_S_ADDR_LSB +: 16] <= cur_addr_q;
        end
        `FIO_OFS_POST: avs_readdata <= {24'h000000, post_q};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_q <= `FIO_CTRL_RST;
    end else if (avs_write && !avs_waitrequest && avs_address == `FIO_OFS_CTRL) begin
      ctrl_q <= avs_writedata[`FIO_CTRL_W-1:0];
    end
  end

  // -------------------------------------------------------------
  // Cycle sequencer
  // -------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      io_busy <= 1'b0;
      io_done <= 1'b0;
      io_rdata <= 8'h00;
      tgt_req <= 1'b0;
      tgt_sel <= TGT_NONE;
      tgt_sideband <= 1'b0;
      tgt_write <= 1'b0;
      tgt_addr <= 16'h0000;
      tgt_wdata <= 8'h00;
      tgt_nmi_copy <= 1'b0;
      last_tgt_q <= TGT_NONE;
      cur_addr_q <= 16'h0000;
      cur_wr_q <= 1'b0;
      cur_wdata_q <= 8'h00;
    end else begin
      io_done <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (io_req) begin
            cur_addr_q <= io_addr;
            cur_wr_q <= io_write;
            cur_wdata_q <= io_wdata;
            io_busy <= 1'b1;
            state_q <= ST_DEC;
          end
        end
        ST_DEC: begin
          last_tgt_q <= dec_tgt;
          if (dec_local) begin
            io_done <= 1'b1;
            io_busy <= 1'b0;
            io_rdata <= (dec_tgt == TGT_LOCAL) ? post_q : `FIO_ALL_ONES;
            state_q <= ST_IDLE;
          end else begin
            tgt_req <= 1'b1;
            tgt_sel <= dec_tgt;
            tgt_sideband <= dec_internal;
            tgt_write <= cur_wr_q;
            tgt_addr <= dec_addr;
            tgt_wdata <= cur_wdata_q;
            tgt_nmi_copy <= dec_nmi;
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (tgt_ack) begin
            tgt_req <= 1'b0;
            tgt_nmi_copy <= 1'b0;
            io_done <= 1'b1;
            io_busy <= 1'b0;
            io_rdata <= tgt_write ? 8'h00 : tgt_rdata;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // POST-code shadow for internally answered reads
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      post_q <= `FIO_POST_RST;
    end else if (state_q == ST_DEC && cur_wr_q && dec_post && !dec_local) begin
      post_q <= cur_wdata_q;
    end
  end

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  a_rw_split: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_DEC && dec_post && ctrl_q[`FIO_B_POST_RD_LOCAL]
     && cur_addr_q[3:0] inside {4'h0, 4'h4, 4'h5, 4'h6, 4'h8, 4'hc, 4'hd, 4'he})
    |=> (cur_wr_q ? tgt_req : (!tgt_req && io_done && io_rdata == post_q)))
    else $error("post-code read/write split wrong");

  a_rsvd_ones: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_DEC && dec_tgt == TGT_RSVD)
    |=> io_done && !tgt_req && io_rdata == 8'hff)
    else $error("reserved cycle not completed with all ones");

  a_none_term: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_DEC && cur_addr_q == 16'h0300)
    |=> io_done && !tgt_req && state_q == ST_IDLE)
    else $error("unlisted address not terminated");

  a_sb_claim: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_DEC && dec_internal) |=> tgt_req && tgt_sideband)
    else $error("internal unit cycle not on sideband");

  a_pic_route: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_DEC && cur_addr_q[15:8] == 8'h00 && !cur_addr_q[1]
     && (cur_addr_q[7:5] == 3'h1 || cur_addr_q[7:5] == 3'h5))
    |=> tgt_req && tgt_sel == TGT_PIC)
    else $error("interrupt port not routed to interrupt unit");

  a_pic_high: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_DEC && cur_addr_q[15:1] == 15'h0268)
    |=> tgt_req && tgt_sel == TGT_PIC)
    else $error("4d0h pair not routed to interrupt unit");

  a_fwd_gate: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_DEC && cur_addr_q[15:1] == 15'h0017)
    |=> (tgt_req == $past(ctrl_q[`FIO_B_SUPERIO])))
    else $error("super-io forward ignores its enable");

  a_nmi_alias: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_DEC && cur_addr_q inside {16'h0063, 16'h0065, 16'h0067})
    |=> (ctrl_q[`FIO_B_NMI_ALIAS] ? (tgt_sel == TGT_NMI && tgt_addr == 16'h0061)
         : (io_done && !tgt_req)))
    else $error("nmi alias port handled wrong");

  a_rtc_alias: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_DEC && cur_addr_q == 16'h0076 && !ctrl_q[`FIO_B_RTC_UPPER])
    |=> tgt_sel == TGT_RTC && tgt_addr == 16'h0070 && tgt_nmi_copy == tgt_write)
    else $error("rtc upper bank alias wrong");

  a_post_route: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_DEC && (cur_addr_q == 16'h0080 || cur_addr_q == 16'h0084) && cur_wr_q)
    |=> tgt_req && ((tgt_sel == TGT_PCIE) == ctrl_q[`FIO_B_POST_ROUTE]))
    else $error("post-code route bit not obeyed");

  a_post_write: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_DEC && dec_post && cur_wr_q && cur_addr_q[3:0] == 4'hc)
    |=> tgt_req && tgt_write)
    else $error("post-code write not forwarded");

  a_legacy_strap: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (tgt_req && tgt_sel inside {TGT_LPC, TGT_ESPI})
    |-> (tgt_sel == TGT_ESPI) == strap_q)
    else $error("legacy bus choice disagrees with strap");
endmodule

// ==== fio_tgt_model.sv ====
// Far-side target model answering decoded cycles
`timescale 1ns/1ps
module fio_tgt_model
  import fio_pkg::*;
(
  // Clock and answer speed
  input wire logic sys_clk,
  input wire logic slow,
  // Decoded cycle
  input wire logic tgt_req,
  input wire fio_tgt_type tgt_sel,
  input wire logic tgt_write,
  input wire logic tgt_sideband,
  input wire logic [15:0] tgt_addr,
  input wire logic [7:0] tgt_wdata,
  input wire logic tgt_nmi_copy,
  // Answer
  output logic tgt_ack,
  output logic [7:0] tgt_rdata,
  // Record of the last answered cycle
  output fio_tgt_type last_sel,
  output logic [15:0] last_addr,
  output logic [7:0] last_wdata,
  output logic last_wr,
  output logic last_sb,
  output logic last_nmi,
  output logic [15:0] acks
);
  logic [2:0] cnt_q;

  initial begin
    tgt_ack = 1'b0;
    tgt_rdata = 8'h00;
    cnt_q = 3'h0;
    acks = 16'h0000;
  end

  // Read data toggles outside the answer cycle
  always @(posedge sys_clk) begin
    if (tgt_req && !tgt_ack && cnt_q >= (slow ? 3'h4 : 3'h0)) begin
      tgt_ack <= 1'b1;
      tgt_rdata <= tgt_addr[7:0] ^ 8'ha5;
      cnt_q <= 3'h0;
      last_sel <= tgt_sel;
      last_addr <= tgt_addr;
      last_wdata <= tgt_wdata;
      last_wr <= tgt_write;
      last_sb <= tgt_sideband;
      last_nmi <= tgt_nmi_copy;
      acks <= acks + 16'h0001;
    end else begin
      tgt_ack <= 1'b0;
      tgt_rdata <= ~tgt_rdata;
      if (tgt_req && !tgt_ack) begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end
endmodule

// ==== testbench.sv ====
// Self-checking bench for the fixed I/O decoder
`timescale 1ns/1ps
module testbench
  import fio_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic espi_strap = 1'b0;
  logic slow = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic io_req = 1'b0;
  logic io_write = 1'b0;
  logic [15:0] io_addr = 16'h0, tgt_addr, last_addr, acks;
  logic [7:0] io_wdata = 8'h0, io_rdata, tgt_wdata, tgt_rdata, last_wdata;
  logic avs_waitrequest, io_busy, io_done, tgt_req, tgt_sideband, tgt_write;
  logic tgt_nmi_copy, tgt_ack, last_wr, last_sb, last_nmi;
  fio_tgt_type tgt_sel, last_sel;
  int fails = 0;
  int cmp_count = 0;

  always #4 sys_clk = ~sys_clk;

  fio_top dut (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .espi_strap, .io_req, .io_write, .io_addr, .io_wdata,
    .io_busy, .io_done, .io_rdata, .tgt_req, .tgt_sel, .tgt_sideband, .tgt_write, .tgt_addr,
    .tgt_wdata, .tgt_nmi_copy, .tgt_ack, .tgt_rdata);

  fio_tgt_model model (.sys_clk, .slow, .tgt_req, .tgt_sel, .tgt_write, .tgt_sideband,
    .tgt_addr, .tgt_wdata, .tgt_nmi_copy, .tgt_ack, .tgt_rdata, .last_sel, .last_addr,
    .last_wdata, .last_wr, .last_sb, .last_nmi, .acks);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_sel(input fio_tgt_type got, input fio_tgt_type exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t target %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      wrap_up();
    end
  endtask

  task automatic io(input logic w, input logic [15:0] a, input fio_tgt_type es,
                    input logic [15:0] ea);
    logic [15:0] n0;
    logic fwd;
    int k;
    n0 = acks;
    fwd = !(es inside {TGT_NONE, TGT_RSVD, TGT_LOCAL});
    k = 0;
    @(posedge sys_clk);
    io_req <= 1'b1;
    io_write <= w;
    io_addr <= a;
    io_wdata <= a[7:0] ^ 8'h3c;
    @(posedge sys_clk);
    io_req <= 1'b0;
    @(posedge sys_clk);
    chk(io_busy, 1'b1);
    k = 1;
    while (io_done !== 1'b1 && k < 40) begin
      @(posedge sys_clk);
      k++;
    end
    if (io_done !== 1'b1) begin
      fails++;
      wrap_up();
    end
    chk(io_busy, 1'b0);
    if (fwd) begin
      chk(acks, n0 + 16'h1);
      chk_sel(last_sel, es);
      chk(last_addr, ea);
      chk(last_wr, w);
      chk(last_sb, es < TGT_LPC);
      chk(last_nmi, w && ea == 16'h0070);
      if (w) chk(last_wdata, a[7:0] ^ 8'h3c);
    end else begin
      chk(acks, n0);
    end
    // Locally served POST-code reads carry the expected byte in ea
    if (!w) chk(io_rdata, fwd ? ea[7:0] ^ 8'ha5 : (es == TGT_LOCAL ? ea[7:0] : 8'hff));
  endtask

  task automatic do_reset(input logic s);
    rst_n <= 1'b0;
    espi_strap <= s;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    av(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h0);
    av(1'b1, 4'h0, 32'hffffffff);
    av(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h000003ff);
    av(1'b1, 4'hc, 32'h1);
    av(1'b1, 4'h0, 32'h0);
    av(1'b0, 4'hc, 32'h0);
    chk(rd, 32'h0);
    av(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h0);
    $display("t_regs done");
  endtask

  task automatic t_pic();
    logic [15:0] pa [10] = '{16'h20, 16'h21, 16'h24, 16'h3d, 16'ha0, 16'ha1, 16'hb4,
                             16'hbd, 16'h4d0, 16'h4d1};
    slow <= 1'b1;
    foreach (pa[i]) begin
      io(1'b0, pa[i], TGT_PIC, pa[i]);
      io(1'b1, pa[i], TGT_PIC, pa[i]);
    end
    io(1'b0, 16'h40, TGT_PIT, 16'h40);
    io(1'b1, 16'hb2, TGT_PM, 16'hb2);
    io(1'b0, 16'hcf9, TGT_RSTGEN, 16'hcf9);
    slow <= 1'b0;
    $display("t_pic done");
  endtask

  task automatic t_rsvd();
    io(1'b0, 16'h41, TGT_RSVD, 16'h41);
    io(1'b1, 16'h51, TGT_RSVD, 16'h51);
    io(1'b0, 16'h300, TGT_NONE, 16'h300);
    io(1'b1, 16'h1000, TGT_NONE, 16'h1000);
    $display("t_rsvd done");
  endtask

  task automatic t_fwd(input fio_tgt_type bus);
    logic [15:0] fa [8] = '{16'h2e, 16'h4f, 16'h60, 16'h64, 16'h62, 16'h66, 16'h200, 16'h20f};
    int fb [8] = '{0, 1, 3, 3, 2, 2, 4, 5};
    foreach (fa[i]) begin
      av(1'b1, 4'h0, 32'h0);
      io(1'b0, fa[i], TGT_NONE, fa[i]);
      av(1'b1, 4'h0, 32'h1 << fb[i]);
      io(1'b0, fa[i], bus, fa[i]);
      io(1'b1, fa[i], bus, fa[i]);
    end
    av(1'b1, 4'h0, 32'h0);
    $display("t_fwd done");
  endtask

  task automatic t_nmi();
    io(1'b0, 16'h61, TGT_NMI, 16'h61);
    io(1'b1, 16'h63, TGT_NONE, 16'h63);
    io(1'b0, 16'h67, TGT_NONE, 16'h67);
    av(1'b1, 4'h0, 32'h40);
    io(1'b1, 16'h65, TGT_NMI, 16'h61);
    io(1'b0, 16'h63, TGT_NMI, 16'h61);
    av(1'b1, 4'h0, 32'h0);
    $display("t_nmi done");
  endtask

  task automatic t_rtc();
    io(1'b1, 16'h70, TGT_RTC, 16'h70);
    io(1'b0, 16'h70, TGT_RTC, 16'h70);
    io(1'b1, 16'h72, TGT_RTC, 16'h70);
    io(1'b0, 16'h77, TGT_RTC, 16'h71);
    io(1'b0, 16'h74, TGT_RTC, 16'h74);
    io(1'b1, 16'h76, TGT_RTC, 16'h70);
    av(1'b1, 4'h0, 32'h80);
    io(1'b1, 16'h72, TGT_RTC, 16'h72);
    io(1'b0, 16'h76, TGT_RTC, 16'h76);
    av(1'b1, 4'h0, 32'h0);
    $display("t_rtc done");
  endtask

  task automatic t_post();
    io(1'b1, 16'h80, TGT_LPC, 16'h80);
    io(1'b0, 16'h8e, TGT_LPC, 16'h8e);
    av(1'b1, 4'h0, 32'h100);
    io(1'b1, 16'h84, TGT_PCIE, 16'h84);
    io(1'b0, 16'h88, TGT_PCIE, 16'h88);
    av(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h000000b8);
    av(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h008800b0);
    av(1'b1, 4'h0, 32'h300);
    io(1'b0, 16'h8c, TGT_LOCAL, 16'h00b8);
    io(1'b1, 16'h8d, TGT_PCIE, 16'h8d);
    av(1'b1, 4'h0, 32'h0);
    $display("t_post done");
  endtask

  task automatic t_strap();
    do_reset(1'b1);
    av(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h1);
    t_fwd(TGT_ESPI);
    io(1'b1, 16'h8c, TGT_ESPI, 16'h8c);
    $display("t_strap done");
  endtask

  initial begin
    do_reset(1'b0);
    t_regs();
    t_pic();
    t_rsvd();
    t_fwd(TGT_LPC);
    t_nmi();
    t_rtc();
    t_post();
    t_strap();
    wrap_up();
  end
endmodule
